// ---- hw/pts_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface pts_link_if;
   import pts_pkg::*;
   logic               sync;         // SYNC broadcast pulse
   logic               rpdo_valid;   // Master to slave object
   logic [PARAM_W-1:0] rpdo_data;
   logic               tpdo_valid;   // Slave to master object
   logic [PARAM_W-1:0] tpdo_data;
   logic               tpdo_ready;   // Master can take it

   modport master (output sync, output rpdo_valid, output rpdo_data,
                   input tpdo_valid, input tpdo_data, output tpdo_ready);
   modport slave  (input sync, input rpdo_valid, input rpdo_data,
                   output tpdo_valid, output tpdo_data, input tpdo_ready);
endinterface
`default_nettype wire

// ---- hw/pts_master.sv ----
// Function
// RL1 - Receive objects go master to slave only
// RL2 - Master broadcasts SYNC every configured period
// RL3 - Asynchronous objects sent on change, no SYNC
// RL4 - Type 0: send on change, apply at SYNC
// RL5 - Type 0 transmit: slave sends on change+SYNC
// RL6 - Type N: send every N SYNCs, apply next
// RL7 - Type N transmit: every N SYNCs, valid now
// RL8 - Type 254: send on change, apply at once
// RL9 - Type 254 transmit: once per event period
// RL10 - Type 254 transmit: inhibit time after sending
// RL11 - Both timers zero: transmit on every change
// RL12 - Type 255 behaves exactly as 254
// RL13 - 32-bit value spans two words, low first
// RL14 - Fast monitored values use synchronous types
// RL15 - Per-object SYNC counter restarts on reaching N
`timescale 1ns/1ps
`default_nettype none
module pts_fifo #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             clock,
   input  wire logic             resetn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic [AW:0]      next_wr_ptr;
   logic [AW:0]      next_rd_ptr;
   logic             push;
   logic             pop;

   // Pointer arithmetic with wrap bit
   always_comb begin
      in_ready    = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
      out_valid   = wr_ptr != rd_ptr;
      out_data    = mem[rd_ptr[AW-1:0]];
      push        = in_valid && in_ready;
      pop         = out_valid && out_ready;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
   end

   // Pointer registers
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   // Storage, no reset needed
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
endmodule // pts_fifo

module pts_master
   import pts_pkg::*;
#(
   parameter int unsigned SYNC_CYC   = SYNC_PERIOD_CYC,
   parameter int unsigned FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   pts_link_if.master       link
);
   logic               sync_en;
   logic [7:0]         rx_type;
   logic [31:0]        period;
   logic [WORD_W-1:0]  word0;
   logic [WORD_W-1:0]  word1;
   logic [31:0]        sync_cnt;
   logic [7:0]         rx_cnt;
   logic               changed;
   logic               dp_wr;
   logic [7:0]         dp_addr;
   logic               next_sync_en;
   logic [7:0]         next_rx_type;
   logic [31:0]        next_period;
   logic [WORD_W-1:0]  next_word0;
   logic [WORD_W-1:0]  next_word1;
   logic [31:0]        next_sync_cnt;
   logic [7:0]         next_rx_cnt;
   logic               next_changed;
   logic               next_dp_wr;
   logic [7:0]         next_dp_addr;
   logic [31:0]        next_hrdata;
   logic               next_sync;
   logic               next_rpdo_valid;
   logic [PARAM_W-1:0] next_rpdo_data;
   logic               addr_ok;
   logic               word_wr;
   logic               send;
   logic               fifo_valid;
   logic               fifo_ready;
   logic               fifo_pop;
   logic               fifo_push;
   logic [PARAM_W-1:0] fifo_data;

   // Received transmit objects queue up for software
   pts_fifo #(.WIDTH(PARAM_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock     (clock),
      .resetn    (resetn),
      .in_valid  (fifo_push),
      .in_ready  (fifo_ready),
      .in_data   (link.tpdo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

   // Bus decode, register writes, SYNC and send scheduling
   always_comb begin
      addr_ok      = hsel && htrans[1] && hready;
      fifo_push    = link.tpdo_valid && link.tpdo_ready;       // [RL1]
      next_dp_wr   = addr_ok && hwrite;
      next_dp_addr = addr_ok ? haddr[7:0] : dp_addr;
      fifo_pop     = addr_ok && !hwrite && haddr[7:0] == REG_TXDATA;
      next_sync_en = sync_en;
      next_rx_type = rx_type;
      next_period  = period;
      next_word0   = word0;
      next_word1   = word1;
      word_wr      = 1'b0;
      if (dp_wr) begin
         case (dp_addr)
            REG_CTRL: begin
               next_sync_en = hwdata[CTRL_SYNC_EN];
               next_rx_type = hwdata[CTRL_TYPE_LSB +: 8];
            end
            REG_PERIOD: next_period = hwdata;
            REG_WORD0: begin
               next_word0 = hwdata[WORD_W-1:0];
               word_wr    = 1'b1;
            end
            REG_WORD1: begin
               next_word1 = hwdata[WORD_W-1:0];
               word_wr    = 1'b1;
            end
            default: ;
         endcase
      end
      // Read data, registered for the data phase
      next_hrdata = 32'h0000_0000;
      if (addr_ok && !hwrite) begin
         case (haddr[7:0])
            REG_CTRL: begin
               next_hrdata[CTRL_SYNC_EN]       = sync_en;
               next_hrdata[CTRL_TYPE_LSB +: 8] = rx_type;
            end
            REG_PERIOD: next_hrdata = period;
            REG_WORD0:  next_hrdata[WORD_W-1:0] = word0;
            REG_WORD1:  next_hrdata[WORD_W-1:0] = word1;
            REG_STATUS: begin
               next_hrdata[ST_AVAIL]         = fifo_valid;
               next_hrdata[ST_FULL]          = !fifo_ready;
               next_hrdata[ST_PEND]          = changed;
               next_hrdata[ST_CNT_LSB +: 8]  = rx_cnt;
            end
            REG_TXDATA: next_hrdata = fifo_valid ? fifo_data : 32'h0;
            default: ;
         endcase
      end
      // SYNC period timer
      next_sync     = 1'b0;
      next_sync_cnt = 32'h0000_0000;
      if (sync_en) begin
         if (sync_cnt + 32'h1 >= period) begin
            next_sync = 1'b1;                             // [RL2]
         end else begin
            next_sync_cnt = sync_cnt + 32'h1;             // [RL2]
         end
      end
      // Cyclic counter and send decision
      next_rx_cnt = rx_cnt;
      send        = 1'b0;
      if (pts_cyclic(rx_type)) begin
         if (link.sync) begin
            if (rx_cnt + 8'h01 >= rx_type) begin
               send        = 1'b1;                        // [RL6] [RL15]
               next_rx_cnt = 8'h00;                       // [RL15]
            end else begin
               next_rx_cnt = rx_cnt + 8'h01;              // [RL15]
            end
         end
      end else begin
         next_rx_cnt = 8'h00;
         // Types 0, 254 and 255 go out on change only
         if (rx_type == TT_ACYCLIC || pts_async(rx_type)) begin
            send = changed;                          // [RL3] [RL4] [RL8] [RL12]
         end
      end
      // A new write during a send keeps the change pending
      next_changed    = word_wr || (changed && !send);
      next_rpdo_valid = send;                             // [RL1]
      next_rpdo_data  = send ? {word1, word0} : link.rpdo_data; // [RL13]
   end

   // State registers
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sync_en         <= CTRL_EN_RST;
         rx_type         <= CTRL_TYPE_RST;
         period          <= SYNC_CYC;
         word0           <= '0;
         word1           <= '0;
         sync_cnt        <= '0;
         rx_cnt          <= '0;
         changed         <= 1'b0;
         dp_wr           <= 1'b0;
         dp_addr         <= '0;
         hrdata          <= '0;
         hreadyout       <= 1'b1;
         hresp           <= 1'b0;
         link.sync       <= 1'b0;
         link.rpdo_valid <= 1'b0;
         link.rpdo_data  <= '0;
         link.tpdo_ready <= 1'b0;
      end else begin
         sync_en         <= next_sync_en;
         rx_type         <= next_rx_type;
         period          <= next_period;
         word0           <= next_word0;
         word1           <= next_word1;
         sync_cnt        <= next_sync_cnt;
         rx_cnt          <= next_rx_cnt;
         changed         <= next_changed;
         dp_wr           <= next_dp_wr;
         dp_addr         <= next_dp_addr;
         hrdata          <= next_hrdata;
         hreadyout       <= 1'b1;
         hresp           <= 1'b0;
         link.sync       <= next_sync;
         link.rpdo_valid <= next_rpdo_valid;
         link.rpdo_data  <= next_rpdo_data;
         // Valid on arrival; ready only when a slot is sure next cycle
         link.tpdo_ready <= fifo_ready && !fifo_push; // [RL5] [RL7] [RL11]
      end
   end
endmodule // pts_master
`default_nettype wire

// ---- hw/pts_pkg.sv ----
package pts_pkg;
   // Transmission type codes
   localparam logic [7:0] TT_ACYCLIC  = 8'h00;
   localparam logic [7:0] TT_CYC_MIN  = 8'h01;
   localparam logic [7:0] TT_CYC_MAX  = 8'hf0;
   localparam logic [7:0] TT_ASYNC_MF = 8'hfe;
   localparam logic [7:0] TT_ASYNC_DP = 8'hff;
   // Timing
   localparam int unsigned CLOCK_HZ        = 50_000_000;
   localparam int unsigned SYNC_PERIOD_MS  = 50;
   localparam int unsigned SYNC_PERIOD_CYC =
      SYNC_PERIOD_MS * (CLOCK_HZ / 1000);
   // Data widths
   localparam int unsigned WORD_W  = 16;
   localparam int unsigned PARAM_W = 32;
   localparam int unsigned FIFO_DEPTH_DEF = 16;
   // Register offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_PERIOD = 8'h04;
   localparam logic [7:0] REG_WORD0  = 8'h08;
   localparam logic [7:0] REG_WORD1  = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_TXDATA = 8'h14;
   // Control fields and reset values
   localparam int unsigned CTRL_SYNC_EN  = 0;
   localparam int unsigned CTRL_TYPE_LSB = 8;
   localparam logic [7:0]  CTRL_TYPE_RST = TT_ASYNC_DP;
   localparam logic        CTRL_EN_RST   = 1'b1;
   // Status fields
   localparam int unsigned ST_AVAIL  = 0;
   localparam int unsigned ST_FULL   = 1;
   localparam int unsigned ST_PEND   = 2;
   localparam int unsigned ST_CNT_LSB = 8;

   function automatic logic pts_cyclic(input logic [7:0] t);
      return (t >= TT_CYC_MIN) && (t <= TT_CYC_MAX);
   endfunction

   function automatic logic pts_async(input logic [7:0] t);
      return (t == TT_ASYNC_MF) || (t == TT_ASYNC_DP);
   endfunction
endpackage

// ---- hw/pts_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
module pts_slave
   import pts_pkg::*;
(
   input  wire logic               clock,
   input  wire logic               resetn,
   pts_link_if.slave               link,
   input  wire logic [7:0]         rx_type,
   input  wire logic [7:0]         tx_type,
   input  wire logic [31:0]        event_cyc,
   input  wire logic [31:0]        inhibit_cyc,
   input  wire logic [PARAM_W-1:0] tx_value,
   output logic [PARAM_W-1:0]      applied_value,
   output logic                    applied
);
   logic [PARAM_W-1:0] held;
   logic               held_ok;
   logic [PARAM_W-1:0] last_sent;
   logic [7:0]         tx_cnt;
   logic [31:0]        ev_cnt;
   logic [31:0]        inh_cnt;
   logic [PARAM_W-1:0] next_held;
   logic               next_held_ok;
   logic [PARAM_W-1:0] next_applied_value;
   logic               next_applied;
   logic [PARAM_W-1:0] next_last_sent;
   logic [7:0]         next_tx_cnt;
   logic [31:0]        next_ev_cnt;
   logic [31:0]        next_inh_cnt;
   logic               next_tpdo_valid;
   logic [PARAM_W-1:0] next_tpdo_data;
   logic               changed;
   logic               want;
   logic               busy;
   logic               fire;

   // Receive side: apply now or hold for the next SYNC
   always_comb begin
      next_held          = held;
      next_held_ok       = held_ok;
      next_applied_value = applied_value;
      next_applied       = 1'b0;
      if (link.sync && held_ok) begin
         next_applied_value = held;                       // [RL4] [RL6]
         next_applied       = 1'b1;
         next_held_ok       = 1'b0;
      end
      if (link.rpdo_valid) begin                          // [RL1]
         if (pts_async(rx_type)) begin
            next_applied_value = link.rpdo_data;          // [RL8] [RL12]
            next_applied       = 1'b1;
         end else begin
            next_held    = link.rpdo_data;                // [RL4] [RL6]
            next_held_ok = 1'b1;
         end
      end
   end

   // Transmit side: decide when an object goes to the master
   always_comb begin
      busy        = link.tpdo_valid && !link.tpdo_ready;
      changed     = tx_value != last_sent;
      want        = 1'b0;
      next_tx_cnt = tx_cnt;
      next_ev_cnt = ev_cnt;
      if (tx_type == TT_ACYCLIC) begin
         want = changed && link.sync;                     // [RL5]
      end else if (pts_cyclic(tx_type)) begin
         // Synchronous types suit fast monitored values
         if (link.sync) begin
            if (tx_cnt + 8'h01 >= tx_type) begin
               want        = 1'b1;                        // [RL7] [RL14]
               next_tx_cnt = 8'h00;                       // [RL15]
            end else begin
               next_tx_cnt = tx_cnt + 8'h01;              // [RL15]
            end
         end
      end else if (pts_async(tx_type)) begin              // [RL12]
         if (event_cyc == 32'h0) begin
            want = changed;                               // [RL3] [RL11]
         end else if (ev_cnt + 32'h1 >= event_cyc) begin
            want = 1'b1;                                  // [RL9]
         end else begin
            next_ev_cnt = ev_cnt + 32'h1;                 // [RL9]
         end
         want = want && inh_cnt == 32'h0;                 // [RL10]
      end
      fire = want && !busy;
      if (fire) begin
         next_ev_cnt = 32'h0;
      end
      // Inhibit window opens after each send under types 254 and 255
      if (fire && pts_async(tx_type) && inhibit_cyc != 32'h0) begin
         next_inh_cnt = inhibit_cyc;                      // [RL10]
      end else if (inh_cnt != 32'h0) begin
         next_inh_cnt = inh_cnt - 32'h1;                  // [RL10]
      end else begin
         next_inh_cnt = 32'h0;
      end
      next_last_sent  = fire ? tx_value : last_sent;
      next_tpdo_valid = fire || busy;                     // [RL1]
      next_tpdo_data  = fire ? tx_value : link.tpdo_data;
   end

   // State registers
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         held            <= '0;
         held_ok         <= 1'b0;
         applied_value   <= '0;
         applied         <= 1'b0;
         last_sent       <= '0;
         tx_cnt          <= '0;
         ev_cnt          <= '0;
         inh_cnt         <= '0;
         link.tpdo_valid <= 1'b0;
         link.tpdo_data  <= '0;
      end else begin
         held            <= next_held;
         held_ok         <= next_held_ok;
         applied_value   <= next_applied_value;
         applied         <= next_applied;
         last_sent       <= next_last_sent;
         tx_cnt          <= next_tx_cnt;
         ev_cnt          <= next_ev_cnt;
         inh_cnt         <= next_inh_cnt;
         link.tpdo_valid <= next_tpdo_valid;
         link.tpdo_data  <= next_tpdo_data;
      end
   end
endmodule // pts_slave
`default_nettype wire

// ---- testbench/pts_link_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module pts_link_checker
   import pts_pkg::*;
#(
   parameter int SYNC_CYC = 20
) (
   input wire logic        clock,
   input wire logic        resetn,
   input wire logic        sync,
   input wire logic        rpdo_valid,
   input wire logic [31:0] rpdo_data,
   input wire logic        tpdo_valid,
   input wire logic [31:0] tpdo_data,
   input wire logic        tpdo_ready,
   input wire logic [7:0]  rx_type,
   input wire logic [7:0]  tx_type,
   input wire logic [31:0] applied_value,
   input wire logic        applied
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   // Line stays quiet after a pulse
   sequence s_quiet;
      ##1 !sync [*8];
   endsequence
   // New transmit object under a steady sync-bound type
   sequence s_tx_fresh;
      $rose(tpdo_valid) && tx_type <= TT_CYC_MAX
         && tx_type == $past(tx_type, 2);
   endsequence

   a_sync_gap: assert property (sync |-> s_quiet)
      else $error("sync pulse too wide");
   a_sync_period: assert property (sync |-> ##SYNC_CYC sync)
      else $error("sync period wrong");
   a_tx_after_sync: assert property (s_tx_fresh |-> $past(sync))
      else $error("sync-bound send without sync");
   a_tx_every_sync: assert property (
      sync && tx_type == TT_CYC_MIN && tx_type == $past(tx_type)
      && tpdo_ready && !tpdo_valid |=> tpdo_valid)
      else $error("type 1 send missing");
   a_tx_hold: assert property (
      tpdo_valid && !tpdo_ready |=> tpdo_valid && $stable(tpdo_data))
      else $error("transmit object dropped");
   a_rx_async_apply: assert property (
      rpdo_valid && pts_async(rx_type)
      |=> applied && applied_value == $past(rpdo_data))
      else $error("async data not applied");
   a_rx_sync_apply: assert property (
      applied && !pts_async(rx_type) |-> $past(sync))
      else $error("sync data applied off sync");
   a_rx_n_sync: assert property (
      rpdo_valid && pts_cyclic(rx_type) |-> $past(sync))
      else $error("cyclic send off sync");
   a_rpdo_hold: assert property (!rpdo_valid |-> $stable(rpdo_data))
      else $error("receive data moved while idle");
endmodule // pts_link_checker
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pts_pkg::*;
   localparam int SYNC  = 20;
   localparam int LIMIT = 60000;
   logic        clock, resetn, hsel, hwrite, hready, hresp, applied;
   logic [31:0] haddr, hwdata, hrdata, event_cyc, inhibit_cyc;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  rx_type, tx_type;
   logic [31:0] tx_value, applied_value, rd, rd_n, av_n;
   logic        rdy_n, sync_n, trdy_n;
   int          err_count = 0;
   int          checks_done = 0;
   int          cycles = 0;
   int          rx_seen = 0;
   int          tx_taken = 0;

   pts_link_if u_pts_link_if ();
   pts_master #(.SYNC_CYC(SYNC), .FIFO_DEPTH(16)) u_pts_master (
      .clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hready), .hresp(hresp),
      .hrdata(hrdata), .link(u_pts_link_if));
   pts_slave u_pts_slave (
      .clock(clock), .resetn(resetn), .link(u_pts_link_if),
      .rx_type(rx_type), .tx_type(tx_type), .event_cyc(event_cyc),
      .inhibit_cyc(inhibit_cyc), .tx_value(tx_value),
      .applied_value(applied_value), .applied(applied));
   pts_link_checker #(.SYNC_CYC(SYNC)) u_pts_link_checker (
      .clock(clock), .resetn(resetn), .sync(u_pts_link_if.sync),
      .rpdo_valid(u_pts_link_if.rpdo_valid),
      .rpdo_data(u_pts_link_if.rpdo_data),
      .tpdo_valid(u_pts_link_if.tpdo_valid),
      .tpdo_data(u_pts_link_if.tpdo_data),
      .tpdo_ready(u_pts_link_if.tpdo_ready), .rx_type(rx_type),
      .tx_type(tx_type), .applied_value(applied_value), .applied(applied));

   // Clock source
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // Settled samples, link event counts and hang guard
   always @(negedge clock) begin
      rdy_n = hready;
      rd_n = hrdata;
      sync_n = u_pts_link_if.sync;
      av_n = applied_value;
      trdy_n = u_pts_link_if.tpdo_ready;
      if (u_pts_link_if.rpdo_valid === 1'b1) rx_seen++;
      if ((u_pts_link_if.tpdo_valid & trdy_n) === 1'b1) tx_taken++;
      cycles++;
      if (cycles == LIMIT) begin
         err_count++;
         stop_test();
      end
   end

   task automatic stop_test;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp,
                        input string w);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s got %h exp %h", $time, w, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask

   // One single word transfer, address then data phase
   task automatic ahb(input logic [7:0] a, input logic w,
                      input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge clock);
      while (rdy_n !== 1'b1) @(posedge clock);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge clock);
      while (rdy_n !== 1'b1) @(posedge clock);
      rd = rd_n;
      chk32({31'h0, hresp}, 32'h0, "hresp");
   endtask

   task automatic set_rx(input logic [7:0] t);
      rx_type <= t;
      ahb(REG_CTRL, 1'b1, {16'h0, t, 8'h01});
   endtask

   task automatic wait_sync;
      @(posedge clock);
      while (sync_n !== 1'b1) @(posedge clock);
   endtask

   // Empty the transmit buffer through its read port
   task automatic drain(input logic [31:0] exp, input logic cmp,
                        output int pops);
      pops = 0;
      ahb(REG_STATUS, 1'b0, 32'h0);
      while (rd[ST_AVAIL] === 1'b1 && pops < 40) begin
         ahb(REG_TXDATA, 1'b0, 32'h0);
         if (cmp) chk32(rd, exp, "fifo data");
         pops++;
         tick(2);
         ahb(REG_STATUS, 1'b0, 32'h0);
      end
   endtask

   task automatic test_regs;
      ahb(REG_CTRL, 1'b0, 32'h0);
      chk32(rd, {16'h0, CTRL_TYPE_RST, 7'h0, CTRL_EN_RST}, "ctrl");
      ahb(REG_PERIOD, 1'b0, 32'h0);
      chk32(rd, 32'(SYNC), "period");
      ahb(8'h18, 1'b1, 32'hdead_beef);
      ahb(8'h18, 1'b0, 32'h0);
      chk32(rd, 32'h0, "unmapped");
   endtask

   task automatic test_rx_async;
      logic [31:0] d;
      for (int i = 0; i < 2; i++) begin
         d = i ? 32'h8765_4321 : 32'h0102_0304;
         set_rx(i ? TT_ASYNC_DP : TT_ASYNC_MF);
         ahb(REG_WORD0, 1'b1, {16'h0, d[15:0]});
         ahb(REG_WORD1, 1'b1, {16'h0, d[31:16]});
         tick(4);
         chk32(av_n, d, "async apply");
      end
   endtask

   task automatic test_rx_type0;
      logic [31:0] old;
      set_rx(TT_ACYCLIC);
      old = av_n;
      wait_sync();
      ahb(REG_WORD0, 1'b1, 32'h0000_5555);
      tick(4);
      chk32(av_n, old, "held");
      wait_sync();
      tick(2);
      chk32(av_n, {old[31:16], 16'h5555}, "sync apply");
   endtask

   task automatic test_rx_cyclic;
      int n [3] = '{1, 3, 240};
      int base;
      for (int i = 0; i < 3; i++) begin
         set_rx(8'(n[i]));
         tick(2 * n[i] * SYNC);
         base = rx_seen;
         tick(2 * n[i] * SYNC);
         chk32(32'(rx_seen - base), 32'd2, "rx count");
      end
   endtask

   task automatic test_tx;
      int base, pops;
      // Cyclic types 1 and 2, constant value
      tx_value <= 32'hc0de_0001;
      for (int n = 1; n < 3; n++) begin
         tx_type <= 8'(n);
         tick(2 * SYNC);
         base = tx_taken;
         tick(4 * SYNC);
         chk32(32'(tx_taken - base), 32'(4 / n), "tx count");
         // Park on a reserved type so no send races the drain
         tx_type <= 8'hf1;
         tick(3);
         base = tx_taken;
         tick(2 * SYNC);
         chk32(32'(tx_taken - base), 32'd0, "reserved idle");
         drain(32'hc0de_0001, 1'b1, pops);
      end
      // Change-driven with sync
      tx_type <= TT_ACYCLIC;
      tick(3);
      base = tx_taken;
      tick(3 * SYNC);
      chk32(32'(tx_taken - base), 32'd0, "type 0 idle");
      tx_value <= 32'h0000_beef;
      tick(3 * SYNC);
      chk32(32'(tx_taken - base), 32'd1, "type 0 send");
      drain(32'h0000_beef, 1'b1, pops);
      // Event timer on both asynchronous types
      for (int i = 0; i < 2; i++) begin
         tx_type <= i ? TT_ASYNC_DP : TT_ASYNC_MF;
         event_cyc <= 32'd10;
         tick(25);
         drain(32'h0000_beef, 1'b1, pops);
         base = tx_taken;
         tick(100);
         chk32(32'(tx_taken - base), 32'd10, "event");
         drain(32'h0000_beef, 1'b1, pops);
      end
      // Timers off, then inhibit only
      event_cyc <= 32'd0;
      tick(5);
      base = tx_taken;
      for (int k = 0; k < 3; k++) begin
         tx_value <= 32'h100 + 32'(k);
         tick(6);
      end
      chk32(32'(tx_taken - base), 32'd3, "every change");
      inhibit_cyc <= 32'd40;
      tick(50);
      base = tx_taken;
      for (int k = 0; k < 3; k++) begin
         tx_value <= 32'h200 + 32'(k);
         tick(6);
      end
      chk32(32'(tx_taken - base), 32'd1, "inhibit");
      tick(40);
      chk32(32'(tx_taken - base), 32'd2, "after inhibit");
      inhibit_cyc <= 32'd0;
      drain(32'h0, 1'b0, pops);
   endtask

   // Fill the buffer until it refuses, then empty it
   task automatic test_fifo;
      int pops;
      event_cyc <= 32'd2;
      tick(80);
      chk32({31'h0, trdy_n}, 32'h0, "ready when full");
      ahb(REG_STATUS, 1'b0, 32'h0);
      chk32({31'h0, rd[ST_FULL]}, 32'h1, "full flag");
      tx_type <= TT_ACYCLIC;
      event_cyc <= 32'd0;
      drain(32'h0000_0202, 1'b1, pops);
      chk32(32'(pops), 32'd17, "pop count");
   endtask

   // Main sequence
   initial begin
      resetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      rx_type = TT_ASYNC_DP;
      tx_type = TT_ACYCLIC;
      event_cyc = 32'h0;
      inhibit_cyc = 32'h0;
      tx_value = 32'h0;
      tick(6);
      resetn <= 1'b1;
      tick(1);
      test_regs();
      test_rx_async();
      test_rx_type0();
      test_rx_cyclic();
      test_tx();
      test_fifo();
      stop_test();
   end
endmodule // tb
`default_nettype wire
